// ===== rtl/encoder_status_defs.svh
// constants of the encoder status readback and teletext line mask logic
// assumes one 200 MHz clock and the two-wire control port on pins scl and sda
// Notes on behaviour
// - status byte read without subaddress, two addresses
// - status bits: version, captions, zero, sequence, parity
// - version field is fixed read-only identification
// - odd caption ready: clear on 67+68, set encoded
// - even caption ready: clear on 69+6A, set encoded
// - sequence flag marks first field, 4 or 8
// - two mask registers suppress teletext per line
// - mask acts only inside programmed teletext windows
// - window start offset four M-system, else one
`ifndef ENCODER_STATUS_DEFS_SVH
`define ENCODER_STATUS_DEFS_SVH

// 7-bit slave addresses: 88h/89h and 8Ch/8Dh on the wire
`define SLAVE_ADDR_A      7'h44
`define SLAVE_ADDR_B      7'h46
`define BITS_PER_BYTE     4'h8

`define SUB_CAP_ODD_1     8'h67
`define SUB_CAP_ODD_2     8'h68
`define SUB_CAP_EVEN_1    8'h69
`define SUB_CAP_EVEN_2    8'h6A
`define SUB_MASK_LO       8'h7E
`define SUB_MASK_HI       8'h7F

`define STATUS_VERSION_MSB 7
`define STATUS_VERSION_LSB 5
`define STATUS_CC_ODD     4
`define STATUS_CC_EVEN    3
`define STATUS_ZERO       2
`define STATUS_SEQ        1
`define STATUS_PARITY     0

`define SEQ_FIELDS_M      3'h3
`define SEQ_FIELDS_PAL    3'h7
`define WIN_START_M       10'h004
`define WIN_START_OTHER   10'h001
`define WIN_END_M         10'h003
`define WIN_END_OTHER     10'h000
// mask bit 0 covers this line, bit 15 the line fifteen later
`define MASK_FIRST_LINE   10'h007
`define MASK_LINES        10'h010

`define RESET_MASK        8'h00
`define RESET_CC_READY    1'b1
`define RESET_SUBADDR     8'h00
`endif

// ===== rtl/encoder_status_pkg.sv
// types shared by the status readback logic and its serial engine
// assumes encoder_status_defs.svh holds all numeric constants
package encoder_status_pkg;
   typedef enum logic [6:0] {
      st_idle    = 7'b000_0001,
      st_addr    = 7'b000_0010,
      st_addr_ack= 7'b000_0100,
      st_wr_byte = 7'b000_1000,
      st_wr_ack  = 7'b001_0000,
      st_rd_byte = 7'b010_0000,
      st_rd_ack  = 7'b100_0000
   } serial_state_type;
   typedef logic [7:0] byte_type;
endpackage : encoder_status_pkg

// ===== rtl/control_byte_if.sv
// byte-level link between the serial engine and the register logic
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface control_byte_if;
   import encoder_status_pkg::*;
   logic     wr_valid;
   logic     wr_first;
   byte_type wr_data;
   logic     rd_load;
   byte_type rd_data;
   modport engine (output wr_valid, output wr_first, output wr_data,
                   output rd_load, input rd_data);
   modport regs   (input wr_valid, input wr_first, input wr_data,
                   input rd_load, output rd_data);
endinterface : control_byte_if

// ===== rtl/serial_slave_engine.sv
// two-wire slave engine: address match, write bytes, status read bytes
// assumes scl and sda come straight from pins; sda is open drain
`timescale 1ns/10ps
`include "encoder_status_defs.svh"
module serial_slave_engine (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // pins
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   // byte side
   control_byte_if.engine bus
);
   import encoder_status_pkg::*;

   logic [1:0]       scl_sync_ff, sda_sync_ff;
   logic             scl_prev_ff, sda_prev_ff;
   serial_state_type state_ff, nxt_state;
   logic [3:0]       cnt_ff, nxt_cnt;
   byte_type         shift_ff, nxt_shift;
   logic             oe_ff, nxt_oe;
   logic             read_ff, nxt_read;
   logic             more_ff, nxt_more;
   logic             first_ff, nxt_first;
   logic             wr_valid_ff, nxt_wr_valid;
   logic             rd_load_c;
   logic             scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

   assign scl_s    = scl_sync_ff[1];
   assign sda_s    = sda_sync_ff[1];
   assign scl_rise = scl_s & ~scl_prev_ff;
   assign scl_fall = ~scl_s & scl_prev_ff;
   assign start_c  = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
   assign stop_c   = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

   always_comb begin
      nxt_state    = state_ff;
      nxt_cnt      = cnt_ff;
      nxt_shift    = shift_ff;
      nxt_oe       = oe_ff;
      nxt_read     = read_ff;
      nxt_more     = more_ff;
      nxt_first    = first_ff;
      nxt_wr_valid = 1'b0;
      rd_load_c    = 1'b0;
      if (start_c) begin
         nxt_state = st_addr;
         nxt_cnt   = 4'h0;
         nxt_oe    = 1'b0;
      end else if (stop_c) begin
         nxt_state = st_idle;
         nxt_oe    = 1'b0;
      end else begin
         case (state_ff)
            st_addr, st_wr_byte: begin
               if (scl_rise && cnt_ff != `BITS_PER_BYTE) begin
                  nxt_shift = {shift_ff[6:0], sda_s};
                  nxt_cnt   = cnt_ff + 4'h1;
               end else if (scl_fall && cnt_ff == `BITS_PER_BYTE) begin
                  nxt_cnt = 4'h0;
                  if (state_ff == st_wr_byte) begin
                     nxt_state    = st_wr_ack;
                     nxt_oe       = 1'b1;
                     nxt_wr_valid = 1'b1;
                  end else if (shift_ff[7:1] == `SLAVE_ADDR_A ||
                               shift_ff[7:1] == `SLAVE_ADDR_B) begin
                     nxt_state = st_addr_ack;
                     nxt_oe    = 1'b1;
                     nxt_read  = shift_ff[0];
                     nxt_first = 1'b1;
                  end else begin
                     nxt_state = st_idle;
                  end
               end
            end
            st_wr_ack: begin
               if (scl_fall) begin
                  nxt_state = st_wr_byte;
                  nxt_oe    = 1'b0;
                  nxt_first = 1'b0;
               end
            end
            st_addr_ack, st_rd_ack: begin
               if (scl_rise && state_ff == st_rd_ack) begin
                  nxt_more = ~sda_s;
               end else if (scl_fall) begin
                  if (state_ff == st_addr_ack && !read_ff) begin
                     nxt_state = st_wr_byte;
                     nxt_oe    = 1'b0;
                  end else if (state_ff == st_addr_ack || more_ff) begin
                     // no subaddress: every read byte is the status byte
                     nxt_state = st_rd_byte;
                     nxt_shift = bus.rd_data;
                     rd_load_c = 1'b1;
                     nxt_oe    = ~bus.rd_data[7];
                     nxt_cnt   = 4'h1;
                  end else begin
                     nxt_state = st_idle;
                     nxt_oe    = 1'b0;
                  end
               end
            end
            st_rd_byte: begin
               if (scl_fall) begin
                  if (cnt_ff == `BITS_PER_BYTE) begin
                     nxt_state = st_rd_ack;
                     nxt_oe    = 1'b0;
                  end else begin
                     nxt_shift = {shift_ff[6:0], 1'b0};
                     nxt_oe    = ~shift_ff[6];
                     nxt_cnt   = cnt_ff + 4'h1;
                  end
               end
            end
            default: nxt_state = st_idle;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_sync_ff <= 2'b11;
         sda_sync_ff <= 2'b11;
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
         state_ff    <= st_idle;
         cnt_ff      <= 4'h0;
         shift_ff    <= 8'h00;
         oe_ff       <= 1'b0;
         read_ff     <= 1'b0;
         more_ff     <= 1'b0;
         first_ff    <= 1'b0;
         wr_valid_ff <= 1'b0;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], scl_in};
         sda_sync_ff <= {sda_sync_ff[0], sda_in};
         scl_prev_ff <= scl_s;
         sda_prev_ff <= sda_s;
         state_ff    <= nxt_state;
         cnt_ff      <= nxt_cnt;
         shift_ff    <= nxt_shift;
         oe_ff       <= nxt_oe;
         read_ff     <= nxt_read;
         more_ff     <= nxt_more;
         first_ff    <= nxt_first;
         wr_valid_ff <= nxt_wr_valid;
      end
   end

   assign sda_out      = 1'b0;
   assign sda_oe       = oe_ff;
   assign bus.wr_valid = wr_valid_ff;
   assign bus.wr_first = first_ff;
   assign bus.wr_data  = shift_ff;
   assign bus.rd_load  = rd_load_c;
endmodule : serial_slave_engine

// ===== rtl/encoder_status_readback.sv
// status byte readback, caption ready flags and teletext line mask
// assumes line, field and caption events come from same-clock generators
`timescale 1ns/10ps
`include "encoder_status_defs.svh"
module encoder_status_readback #(
   // arbitrary neutral value
   parameter logic [2:0] VERSION_ID = 3'h5
) (
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset,
   // control port pins
   input  wire logic                     scl_in,
   input  wire logic                     sda_in,
   output logic                          sda_out,
   output logic                          sda_oe,
   // writes passed on to the encoder register file
   output logic                          reg_write_strobe,
   output encoder_status_pkg::byte_type  reg_write_addr,
   output encoder_status_pkg::byte_type  reg_write_data,
   // video timing
   input  wire logic                     m_system,
   input  wire logic                     field_start,
   input  wire logic                     field_is_even,
   input  wire logic                     sequence_restart,
   input  wire logic [9:0]               current_line,
   // caption encoder events
   input  wire logic                     odd_caption_encoded,
   input  wire logic                     even_caption_encoded,
   // teletext windows
   input  wire logic                     teletext_enable,
   input  wire logic [9:0]               odd_window_first_line,
   input  wire logic [9:0]               odd_window_last_line,
   input  wire logic [9:0]               even_window_first_line,
   input  wire logic [9:0]               even_window_last_line,
   output logic                          teletext_request_out
);
   import encoder_status_pkg::*;

   control_byte_if bus ();

   serial_slave_engine u_engine (
      .clk     (clk),
      .reset   (reset),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .sda_out (sda_out),
      .sda_oe  (sda_oe),
      .bus     (bus.engine)
   );

   byte_type    subaddr_ff, nxt_subaddr;
   logic        strobe_ff, nxt_strobe;
   byte_type    waddr_ff, nxt_waddr;
   byte_type    wdata_ff, nxt_wdata;
   logic [15:0] mask_ff, nxt_mask;
   logic [1:0]  odd_seen_ff, nxt_odd_seen;
   logic [1:0]  even_seen_ff, nxt_even_seen;
   logic        odd_rdy_ff, nxt_odd_rdy;
   logic        even_rdy_ff, nxt_even_rdy;
   logic [2:0]  seq_cnt_ff, nxt_seq_cnt;
   byte_type    status_ff, nxt_status;
   logic        ttx_ff, nxt_ttx;
   logic        data_wr;

   // window bounds in absolute line numbers
   function automatic logic in_window(input logic [9:0] line,
                                      input logic [9:0] first,
                                      input logic [9:0] last,
                                      input logic       msys);
      logic [9:0] lo;
      logic [9:0] hi;
      lo = first + (msys ? `WIN_START_M : `WIN_START_OTHER);
      hi = last + (msys ? `WIN_END_M : `WIN_END_OTHER);
      return (line >= lo) && (line <= hi);
   endfunction : in_window

   // caption pair tracker: both bytes must land before the flag drops
   function automatic logic [1:0] track_pair(input logic [1:0] seen,
                                             input logic       hit1,
                                             input logic       hit2);
      return seen | {hit2, hit1};
   endfunction : track_pair

   assign data_wr = bus.wr_valid & ~bus.wr_first;

   // register write path
   always_comb begin
      nxt_subaddr = subaddr_ff;
      nxt_strobe  = 1'b0;
      nxt_waddr   = waddr_ff;
      nxt_wdata   = wdata_ff;
      nxt_mask    = mask_ff;
      if (bus.wr_valid && bus.wr_first) begin
         nxt_subaddr = bus.wr_data;
      end else if (data_wr) begin
         nxt_strobe  = 1'b1;
         nxt_waddr   = subaddr_ff;
         nxt_wdata   = bus.wr_data;
         nxt_subaddr = subaddr_ff + 8'h01;
         if (subaddr_ff == `SUB_MASK_LO) begin
            nxt_mask[7:0] = bus.wr_data;
         end else if (subaddr_ff == `SUB_MASK_HI) begin
            nxt_mask[15:8] = bus.wr_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         subaddr_ff <= `RESET_SUBADDR;
         strobe_ff  <= 1'b0;
         waddr_ff   <= `RESET_SUBADDR;
         wdata_ff   <= 8'h00;
         mask_ff    <= {`RESET_MASK, `RESET_MASK};
      end else begin
         subaddr_ff <= nxt_subaddr;
         strobe_ff  <= nxt_strobe;
         waddr_ff   <= nxt_waddr;
         wdata_ff   <= nxt_wdata;
         mask_ff    <= nxt_mask;
      end
   end

   // status flags; an encode event in the clearing cycle keeps the flag set
   always_comb begin
      logic odd_w1;
      logic odd_w2;
      logic even_w1;
      logic even_w2;
      odd_w1  = data_wr && subaddr_ff == `SUB_CAP_ODD_1;
      odd_w2  = data_wr && subaddr_ff == `SUB_CAP_ODD_2;
      even_w1 = data_wr && subaddr_ff == `SUB_CAP_EVEN_1;
      even_w2 = data_wr && subaddr_ff == `SUB_CAP_EVEN_2;
      nxt_odd_seen  = track_pair(odd_seen_ff, odd_w1, odd_w2);
      nxt_even_seen = track_pair(even_seen_ff, even_w1, even_w2);
      nxt_odd_rdy   = odd_rdy_ff;
      nxt_even_rdy  = even_rdy_ff;
      if (nxt_odd_seen == 2'b11) begin
         nxt_odd_rdy  = 1'b0;
         nxt_odd_seen = 2'b00;
      end
      if (nxt_even_seen == 2'b11) begin
         nxt_even_rdy  = 1'b0;
         nxt_even_seen = 2'b00;
      end
      if (odd_caption_encoded) begin
         nxt_odd_rdy = 1'b1;
      end
      if (even_caption_encoded) begin
         nxt_even_rdy = 1'b1;
      end
      nxt_seq_cnt = seq_cnt_ff;
      if (sequence_restart) begin
         nxt_seq_cnt = 3'h0;
      end else if (field_start) begin
         // wrap after four fields in M-systems, eight otherwise
         if (seq_cnt_ff >= (m_system ? `SEQ_FIELDS_M : `SEQ_FIELDS_PAL)) begin
            nxt_seq_cnt = 3'h0;
         end else begin
            nxt_seq_cnt = seq_cnt_ff + 3'h1;
         end
      end
      nxt_status = 8'h00;
      nxt_status[`STATUS_VERSION_MSB:`STATUS_VERSION_LSB] = VERSION_ID;
      nxt_status[`STATUS_CC_ODD]  = odd_rdy_ff;
      nxt_status[`STATUS_CC_EVEN] = even_rdy_ff;
      nxt_status[`STATUS_ZERO]    = 1'b0;
      nxt_status[`STATUS_SEQ]     = (seq_cnt_ff == 3'h0);
      nxt_status[`STATUS_PARITY]  = field_is_even;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         odd_seen_ff  <= 2'b00;
         even_seen_ff <= 2'b00;
         odd_rdy_ff   <= `RESET_CC_READY;
         even_rdy_ff  <= `RESET_CC_READY;
         seq_cnt_ff   <= 3'h0;
         status_ff    <= 8'h00;
      end else begin
         odd_seen_ff  <= nxt_odd_seen;
         even_seen_ff <= nxt_even_seen;
         odd_rdy_ff   <= nxt_odd_rdy;
         even_rdy_ff  <= nxt_even_rdy;
         seq_cnt_ff   <= nxt_seq_cnt;
         status_ff    <= nxt_status;
      end
   end

   // teletext line gate: window first, the mask can only remove lines
   always_comb begin
      logic       win;
      logic       masked;
      logic [9:0] idx;
      win    = field_is_even ?
               in_window(current_line, even_window_first_line,
                         even_window_last_line, m_system) :
               in_window(current_line, odd_window_first_line,
                         odd_window_last_line, m_system);
      idx    = current_line - `MASK_FIRST_LINE;
      masked = (current_line >= `MASK_FIRST_LINE) && (idx < `MASK_LINES) &&
               mask_ff[idx[3:0]];
      nxt_ttx = teletext_enable & win & ~masked;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ttx_ff <= 1'b0;
      end else begin
         ttx_ff <= nxt_ttx;
      end
   end

   assign bus.rd_data          = status_ff;
   assign reg_write_strobe     = strobe_ff;
   assign reg_write_addr       = waddr_ff;
   assign reg_write_data       = wdata_ff;
   assign teletext_request_out = ttx_ff;
endmodule : encoder_status_readback

// ===== verification/i2c_host_model.sv
// two-wire host model: start, stop, byte write with ack, byte read
// assumes sda is pulled up outside and sda_low pulls it down
`timescale 1ns/10ps
module i2c_host_model (
   // clock
   input  wire logic clk,
   // bus
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_low
);
   // eight clocks a quarter bit leaves room for the device's sync lag
   localparam int QTR = 8;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic step(input logic s, input logic c);
      sda_low = s;
      scl = c;
      repeat (QTR) @(negedge clk);
   endtask : step
   task automatic start();
      step(1'b0, scl);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask : start
   task automatic stop();
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask : stop
   // data changes only while scl is low
   task automatic bit_io(input logic b, output logic r);
      step(!b, 1'b0);
      step(!b, 1'b1);
      r = sda_wire;
      step(!b, 1'b1);
      step(!b, 1'b0);
   endtask : bit_io
   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask : put
   // read starts straight after the address, no subaddress phase
   task automatic get(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
   endtask : get
endmodule : i2c_host_model

// ===== verification/encoder_status_readback_chk.sv
// port checker of the status readback block, bound to its top module
// assumes one clock with synchronous active high reset
`timescale 1ns/10ps
`include "encoder_status_defs.svh"
module encoder_status_readback_chk (
   // clock and reset
   input wire logic                         clk,
   input wire logic                         reset,
   // control port
   input wire logic                         scl_in,
   input wire logic                         sda_out,
   input wire logic                         sda_oe,
   input wire logic                         reg_write_strobe,
   input wire encoder_status_pkg::byte_type reg_write_addr,
   input wire encoder_status_pkg::byte_type reg_write_data,
   // teletext
   input wire logic                         m_system,
   input wire logic                         field_is_even,
   input wire logic [9:0]                   current_line,
   input wire logic                         teletext_enable,
   input wire logic [9:0]                   odd_window_first_line,
   input wire logic [9:0]                   odd_window_last_line,
   input wire logic [9:0]                   even_window_first_line,
   input wire logic [9:0]                   even_window_last_line,
   input wire logic                         teletext_request_out
);
   import encoder_status_pkg::*;
   logic [15:0] mask_ff, nxt_mask;
   logic [2:0]  high_ff, nxt_high;
   logic [9:0]  lo, hi;
   logic        tt_exp;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // mask copy rebuilt from the forwarded write stream
   always_comb begin
      nxt_mask = mask_ff;
      if (reg_write_strobe && reg_write_addr == `SUB_MASK_LO) nxt_mask[7:0] = reg_write_data;
      if (reg_write_strobe && reg_write_addr == `SUB_MASK_HI) nxt_mask[15:8] = reg_write_data;
      nxt_high = !scl_in ? 3'h0 : (high_ff == 3'h7) ? 3'h7 : high_ff + 3'h1;
   end
   always_ff @(posedge clk) begin
      mask_ff <= reset ? 16'h0000 : nxt_mask;
      high_ff <= reset ? 3'h0 : nxt_high;
   end
   always_comb begin
      lo = (field_is_even ? even_window_first_line : odd_window_first_line)
         + (m_system ? `WIN_START_M : `WIN_START_OTHER);
      hi = (field_is_even ? even_window_last_line : odd_window_last_line)
         + (m_system ? `WIN_END_M : `WIN_END_OTHER);
      tt_exp = teletext_enable && current_line >= lo && current_line <= hi
         && !(current_line >= `MASK_FIRST_LINE && current_line < `MASK_FIRST_LINE + `MASK_LINES
         && mask_ff[current_line - `MASK_FIRST_LINE]);
   end
   strobe_one_pulse_a: assert property (reg_write_strobe |=> !reg_write_strobe)
      else $error("write strobe longer than one cycle");
   write_hold_a: assert property (!reg_write_strobe |-> $stable(reg_write_addr)
      && $stable(reg_write_data)) else $error("write address or data moved without strobe");
   // a mask write may land a cycle early or late, so skip two cycles after one
   tt_exact_a: assert property (!$past(reset) && !reg_write_strobe && !$past(reg_write_strobe)
      && !$past(reg_write_strobe, 2) |-> teletext_request_out == $past(tt_exp))
      else $error("teletext request differs from window and mask");
   tt_disabled_a: assert property (!teletext_enable |=> !teletext_request_out)
      else $error("teletext request while insertion is off");
   sda_steady_a: assert property (high_ff >= 3'h5 |-> $stable(sda_oe))
      else $error("sda drive changed while scl high");
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   strobe_scl_low_a: assert property ($rose(reg_write_strobe) |-> !scl_in)
      else $error("write strobe while scl high");
   sda_after_reset_a: assert property ($past(reset) |-> !sda_oe)
      else $error("sda pulled low right after reset");
   cover property (reg_write_strobe);
   cover property ($rose(teletext_request_out));
   cover property ($rose(sda_oe));
endmodule : encoder_status_readback_chk
bind encoder_status_readback encoder_status_readback_chk encoder_status_readback_chk_inst (
   .clk, .reset, .scl_in, .sda_out, .sda_oe, .reg_write_strobe, .reg_write_addr,
   .reg_write_data, .m_system, .field_is_even, .current_line, .teletext_enable,
   .odd_window_first_line, .odd_window_last_line, .even_window_first_line,
   .even_window_last_line, .teletext_request_out);

// ===== verification/encoder_status_readback_bench.sv
// self-checking bench: status reads, caption flags, sequence flag, line mask
// assumes the host model on the pins and the checker bound to the block
`timescale 1ns/10ps
`include "encoder_status_defs.svh"
module encoder_status_readback_bench;
   import encoder_status_pkg::*;
   // arbitrary neutral version value
   localparam logic [2:0] VERSION_VAL = 3'h2;
   logic        clk, reset, scl, host_low, sda_out, sda_oe, wr_stb, tt_req;
   byte_type    wr_addr, wr_data;
   logic        m_sys, fld_start, fld_even, seq_rst, odd_enc, even_enc, tt_en;
   logic [9:0]  line, ofirst, olast, efirst, elast;
   logic        cc_odd, cc_even;
   logic [15:0] mask;
   int          error_cnt, total_checks, seq_cnt, n;
   // open drain line with pull-up
   wire         sda_wire = !(sda_oe || host_low);
   encoder_status_readback #(.VERSION_ID(VERSION_VAL)) encoder_status_readback_inst (
      .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .reg_write_strobe(wr_stb), .reg_write_addr(wr_addr),
      .reg_write_data(wr_data), .m_system(m_sys), .field_start(fld_start),
      .field_is_even(fld_even), .sequence_restart(seq_rst), .current_line(line),
      .odd_caption_encoded(odd_enc), .even_caption_encoded(even_enc),
      .teletext_enable(tt_en), .odd_window_first_line(ofirst),
      .odd_window_last_line(olast), .even_window_first_line(efirst),
      .even_window_last_line(elast), .teletext_request_out(tt_req));
   i2c_host_model i2c_host_model_inst (.clk(clk), .sda_wire(sda_wire), .scl(scl),
      .sda_low(host_low));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic test_done();
      if (error_cnt == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   // about 19k cycles of traffic expected
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      test_done();
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      @(negedge clk);
   endtask : pulse
   function automatic byte_type exp_status();
      return {VERSION_VAL, cc_odd, cc_even, 1'b0, seq_cnt == 0, fld_even};
   endfunction : exp_status
   function automatic logic tt_exp();
      logic [9:0] lo, hi;
      lo = (fld_even ? efirst : ofirst) + (m_sys ? 10'h004 : 10'h001);
      hi = (fld_even ? elast : olast) + (m_sys ? 10'h003 : 10'h000);
      return tt_en && line >= lo && line <= hi
         && !(line >= 10'h007 && line < 10'h017 && mask[line - 10'h007]);
   endfunction : tt_exp
   task automatic wr(input byte_type sub, input byte_type d0, input byte_type d1);
      logic ack;
      i2c_host_model_inst.start();
      i2c_host_model_inst.put(8'h88, ack);
      i2c_host_model_inst.put(sub, ack);
      i2c_host_model_inst.put(d0, ack);
      i2c_host_model_inst.put(d1, ack);
      i2c_host_model_inst.stop();
      check({wr_addr, wr_data}, {sub + 8'h01, d1});
   endtask : wr
   task automatic rd_chk(input byte_type adr);
      logic     ack;
      byte_type d, d2;
      i2c_host_model_inst.start();
      i2c_host_model_inst.put(adr, ack);
      check(ack, 1'b1);
      i2c_host_model_inst.get(1'b1, d);
      i2c_host_model_inst.get(1'b0, d2);
      i2c_host_model_inst.stop();
      check(d, exp_status());
      check(d2, d);
   endtask : rd_chk
   initial begin
      logic ack;
      reset = 1'b1;
      {m_sys, fld_start, fld_even, seq_rst, odd_enc, even_enc, tt_en} = '0;
      {line, ofirst, olast, efirst, elast} = '0;
      {error_cnt, total_checks, seq_cnt} = '0;
      {cc_odd, cc_even, mask} = {2'b11, 16'h0000};
      void'($urandom(12));
      repeat (5) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      rd_chk(8'h89);
      rd_chk(8'h8d);
      i2c_host_model_inst.start();
      i2c_host_model_inst.put(8'h8b, ack);
      i2c_host_model_inst.stop();
      check(ack, 1'b0);
      // caption pairs split over two transfers, last odd pair written in one transfer
      wr(8'h66, 8'($urandom), 8'($urandom));
      rd_chk(8'h89);
      wr(8'h68, 8'($urandom), 8'($urandom));
      cc_odd = 1'b0;
      rd_chk(8'h8d);
      pulse(odd_enc);
      cc_odd = 1'b1;
      wr(8'h6a, 8'($urandom), 8'($urandom));
      cc_even = 1'b0;
      rd_chk(8'h89);
      pulse(even_enc);
      cc_even = 1'b1;
      wr(8'h67, 8'($urandom), 8'($urandom));
      cc_odd = 1'b0;
      rd_chk(8'h8d);
      // first count is a whole sequence, so the flag must come back
      for (int m = 0; m < 2; m++) begin
         m_sys = m[0];
         pulse(seq_rst);
         seq_cnt = 0;
         for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? (m ? 4 : 8) : int'($urandom_range(7, 1));
            repeat (n) pulse(fld_start);
            seq_cnt = (seq_cnt + n) % (m ? 4 : 8);
            fld_even = 1'($urandom);
            rd_chk(k[0] ? 8'h8d : 8'h89);
         end
      end
      for (int r = 0; r < 2; r++) begin
         mask = r ? 16'hffff : 16'($urandom);
         wr(`SUB_MASK_LO, mask[7:0], mask[15:8]);
         repeat (200) begin
            {m_sys, fld_even} = 2'($urandom);
            tt_en = ($urandom_range(7, 0) != 0);
            {ofirst, efirst} = {10'($urandom_range(20, 0)), 10'($urandom_range(20, 0))};
            {olast, elast} = {10'($urandom_range(30, 5)), 10'($urandom_range(30, 5))};
            line = 10'($urandom_range(36, 0));
            @(negedge clk);
            check(tt_req, tt_exp());
         end
      end
      test_done();
   end
endmodule : encoder_status_readback_bench
